// File: rtl/src_reset_ctrl.sv
// system reset controller: source gathering, pin qualification, sequencing
`timescale 1ns/1ps
`include "src_regs.svh"

// How it works
// - pin held four cycles starts system reset
// - three synchronised low cycles already qualify
// - option one: watchdog timeout causes system reset
// - option zero: watchdog timeout only interrupts
// - watchdog reset sets the watchdog cause flag
// - pin, power-on, watchdog, stop exit, brownout reset
// - brownout recovery runs the power-on sequence
module src_reset_ctrl #(
	parameter int SYS_HOLD_CYC = `SRC_SYS_HOLD_CYC,
	parameter int POR_HOLD_CYC = `SRC_POR_HOLD_CYC
) (
	input wire logic sys_clk_i, // system clock, 100 MHz
	input wire logic nrst_i, // synchronous reset, active low
	input wire logic rst_pin_n_i, // external reset pin, asynchronous
	input wire logic por_i, // power-on detect level, asynchronous
	input wire logic brownout_detect_i, // brownout level, asynchronous
	input wire logic wdt_timeout_i, // watchdog time-out pulse
	input wire logic stop_exit_i, // stop mode exit pulse
	input wire logic watchdog_reset_select_option_i, // static option bit
	input wire logic cause_clear_i, // clears the cause flags, pulse
	output logic sys_rst_n_o, // system reset, active low
	output logic wdt_irq_o, // watchdog interrupt request, pulse
	output src_pkg::src_cause_s reset_cause_register_o // sticky reset causes
);

	src_pkg::src_async_s async_in;
	src_pkg::src_async_s sync1_q;
	src_pkg::src_async_s sync2_q;
	src_pkg::src_pin_cnt_t pin_cnt_q;
	src_pkg::src_state_e st_q;
	src_pkg::src_state_e st_d;
	src_pkg::src_cnt_t cnt_q;
	src_pkg::src_cnt_t cnt_d;
	src_pkg::src_cause_s cause_q;
	src_pkg::src_cause_s cause_set;
	logic sys_rst_n_q;
	logic wdt_irq_q;
	logic pin_s;
	logic por_s;
	logic bo_s;
	logic pin_qual;
	logic wdt_rst;
	logic por_lvl;
	logic sys_req;
	logic run;

	assign async_in = '{por: por_i, brownout: brownout_detect_i, pin_n: rst_pin_n_i};

	// two-stage synchroniser; stage one feeds nothing but stage two
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			// idle levels: pin released high, power-on and brownout low
			sync1_q <= 3'h1;
			sync2_q <= 3'h1;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	assign pin_s = sync2_q.pin_n;
	assign por_s = sync2_q.por;
	assign bo_s = sync2_q.brownout;

	// count consecutive low cycles; a release restarts the count
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pin_cnt_q <= 3'h0;
		end else if (pin_s) begin
			pin_cnt_q <= 3'h0;
		end else if (pin_cnt_q < 3'(`SRC_PIN_QUAL_CYCLES)) begin
			pin_cnt_q <= pin_cnt_q + 3'h1;
		end
	end

	// three counts, not four: sampling phase can eat one edge of the pulse
	assign pin_qual = (pin_cnt_q == 3'(`SRC_PIN_QUAL_CYCLES));
	assign wdt_rst = wdt_timeout_i && watchdog_reset_select_option_i;
	assign por_lvl = por_s || bo_s;
	assign sys_req = pin_qual || wdt_rst || stop_exit_i;
	assign run = (st_q == src_pkg::SRC_RUN);

	// sequencer: power-on class wins, held pin stretches the system pulse
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			src_pkg::SRC_RUN: begin
				if (sys_req) begin
					st_d = src_pkg::SRC_SYS_SEQ;
					cnt_d = 8'(SYS_HOLD_CYC - 1);
				end
			end
			src_pkg::SRC_SYS_SEQ: begin
				if (pin_qual) begin
					cnt_d = 8'(SYS_HOLD_CYC - 1);
				end else if (cnt_q == 8'h00) begin
					st_d = src_pkg::SRC_RUN;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			src_pkg::SRC_POR_SEQ: begin
				if (cnt_q == 8'h00) begin
					st_d = src_pkg::SRC_RUN;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			default: begin
				st_d = src_pkg::SRC_POR_SEQ;
				cnt_d = 8'(POR_HOLD_CYC - 1);
			end
		endcase
		// brownout keeps the counter loaded, so recovery runs a full power-on pulse
		if (por_lvl) begin
			st_d = src_pkg::SRC_POR_SEQ;
			cnt_d = 8'(POR_HOLD_CYC - 1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			st_q <= src_pkg::SRC_POR_SEQ;
			cnt_q <= 8'(POR_HOLD_CYC - 1);
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			sys_rst_n_q <= 1'b0;
		end else begin
			sys_rst_n_q <= (st_d == src_pkg::SRC_RUN);
		end
	end

	// watchdog as interrupt only while the system runs
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			wdt_irq_q <= 1'b0;
		end else begin
			wdt_irq_q <= run && wdt_timeout_i && !watchdog_reset_select_option_i;
		end
	end

	always_comb begin
		cause_set = '0;
		cause_set.pin = run && pin_qual;
		cause_set.stop_exit = run && stop_exit_i;
		cause_set.watchdog_cause_flag = run && wdt_rst;
		cause_set.brownout = bo_s;
		cause_set.por = por_s;
	end

	// set beats a same-cycle clear so no cause is lost
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			cause_q <= `SRC_CAUSE_RESET;
		end else if (cause_clear_i) begin
			cause_q <= cause_set;
		end else begin
			cause_q <= cause_q | cause_set;
		end
	end

	assign sys_rst_n_o = sys_rst_n_q;
	assign wdt_irq_o = wdt_irq_q;
	assign reset_cause_register_o = cause_q;

	AST_PIN_FOUR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(!rst_pin_n_i) [*4] |-> ##[1:8] !sys_rst_n_o)
		else $error("four-cycle pin assertion did not reset");

	AST_PIN_THREE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(!pin_s) [*3] |=> pin_qual)
		else $error("three synchronised low cycles not qualified");

	AST_WDT_RESET: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(run && wdt_timeout_i && watchdog_reset_select_option_i) |=> !run ##0 !sys_rst_n_o)
		else $error("watchdog timeout with option set did not reset");

	AST_WDT_IRQ: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(run && wdt_timeout_i && !watchdog_reset_select_option_i && !pin_qual && !stop_exit_i
			&& !por_lvl) |=> (wdt_irq_o && run && sys_rst_n_o))
		else $error("watchdog interrupt mode misbehaved");

	AST_WDT_FLAG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(run && wdt_rst) |=> reset_cause_register_o.watchdog_cause_flag)
		else $error("watchdog cause flag not set");

	AST_STOP_RESET: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(run && stop_exit_i) |=> !sys_rst_n_o ##1 !sys_rst_n_o)
		else $error("stop exit did not hold reset");

	AST_BO_POR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$fell(bo_s) && !por_s |-> (st_q == src_pkg::SRC_POR_SEQ)
			&& (cnt_q == 8'(POR_HOLD_CYC - 1)))
		else $error("brownout recovery skipped power-on sequence");

	AST_SHORT_PULSE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(run && !pin_qual && !wdt_rst && !stop_exit_i && !por_lvl) |=> run && sys_rst_n_o)
		else $error("reset without qualified source");

	AST_CLEAR_SET: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(cause_clear_i && run && stop_exit_i) |=> reset_cause_register_o.stop_exit)
		else $error("stop exit cause lost to a same-cycle clear");

	COV_PIN: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		run && pin_qual ##1 !sys_rst_n_o);
	COV_WDT_IRQ: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) wdt_irq_o);
	COV_BO: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$fell(bo_s) ##1 (st_q == src_pkg::SRC_POR_SEQ));
	COV_SHORT: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
		run && (pin_cnt_q == 3'h2) ##1 pin_s);

endmodule

// File: rtl/src_regs.svh
// timing counts and field positions of the system reset controller
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH

`define SRC_CLK_PERIOD_NS 10
// least pin assertion the board must give, and the count actually accepted
`define SRC_PIN_MIN_CYCLES 4
`define SRC_PIN_QUAL_CYCLES 3
// length of the reset pulse for system and power-on sequences
`define SRC_SYS_HOLD_NS 160
`define SRC_POR_HOLD_NS 1000
`define SRC_SYS_HOLD_CYC (`SRC_SYS_HOLD_NS / `SRC_CLK_PERIOD_NS)
`define SRC_POR_HOLD_CYC (`SRC_POR_HOLD_NS / `SRC_CLK_PERIOD_NS)
// bit positions of the reset cause vector
`define SRC_CAUSE_PIN_BIT 0
`define SRC_CAUSE_STOP_BIT 1
`define SRC_CAUSE_WDT_BIT 2
`define SRC_CAUSE_BO_BIT 3
`define SRC_CAUSE_POR_BIT 4
`define SRC_CAUSE_RESET 5'h00
`define SRC_CAUSE_WIDTH 5

`endif

// File: rtl/src_pkg.sv
// types shared by the system reset controller
package src_pkg;

	typedef enum logic [1:0] {
		SRC_RUN = 2'b00,
		SRC_SYS_SEQ = 2'b01,
		SRC_POR_SEQ = 2'b10
	} src_state_e;

	typedef logic [7:0] src_cnt_t;
	typedef logic [2:0] src_pin_cnt_t;

	// reset cause flags, msb first
	typedef struct packed {
		logic por;
		logic brownout;
		logic watchdog_cause_flag;
		logic stop_exit;
		logic pin;
	} src_cause_s;

	// asynchronous levels passed through the synchroniser
	typedef struct packed {
		logic por;
		logic brownout;
		logic pin_n;
	} src_async_s;

endpackage

// File: verif/src_pin_drv.sv
// board reset source holding the external reset pin low for a set count
`timescale 1ns/1ps
module src_pin_drv (
	input wire logic clk_i, // system clock
	input wire logic go_i, // start a low pulse
	input wire logic [3:0] len_i, // pulse length in cycles
	output logic pin_n_o // reset pin, pulled up when released
);
	logic [3:0] cnt_q = 4'h0;
	always_ff @(posedge clk_i) begin
		if (go_i)
			cnt_q <= len_i;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
	assign pin_n_o = (cnt_q == 4'h0);
endmodule

// File: verif/system_reset_controller_test.sv
// self-checking bench of the system reset controller
`timescale 1ns/1ps
module system_reset_controller_test;
	localparam int SH = 4;
	localparam int PH = 8;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic por_i = 1'b0, bo_i = 1'b0, dog_i = 1'b0, stop_i = 1'b0;
	logic opt_i = 1'b1, clr_i = 1'b0, go = 1'b0;
	logic [3:0] len = 4'h0;
	logic pin_n, rst_n, irq;
	src_pkg::src_cause_s cause, exp;
	int n_fail = 0, comparisons = 0, seed = 32'h1118, n;

	src_pin_drv src_pin_drv_inst (.clk_i(sys_clk_i), .go_i(go), .len_i(len), .pin_n_o(pin_n));
	src_reset_ctrl #(.SYS_HOLD_CYC(SH), .POR_HOLD_CYC(PH)) src_reset_ctrl_inst (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .rst_pin_n_i(pin_n), .por_i(por_i),
		.brownout_detect_i(bo_i), .wdt_timeout_i(dog_i), .stop_exit_i(stop_i),
		.watchdog_reset_select_option_i(opt_i), .cause_clear_i(clr_i),
		.sys_rst_n_o(rst_n), .wdt_irq_o(irq), .reset_cause_register_o(cause));

	initial forever #5 sys_clk_i = ~sys_clk_i;

	// sample 1 ns after the edge so its updates have landed
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic fail(input string m);
		n_fail++;
		$display("Error %0t: %s", $time, m);
	endtask
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
			fail(m);
	endtask
	task automatic chk_cause;
		comparisons++;
		if (cause !== exp)
			fail("cause flags");
	endtask
	// bounded, so a stuck reset ends here and not at the watchdog
	task automatic settle(input int lo, input int hi);
		n = 0;
		while (rst_n !== 1'b1 && n < 300) begin
			n++;
			cyc(1);
		end
		comparisons++;
		if (n < lo || n > hi)
			fail("reset length");
	endtask
	task automatic clear;
		@(posedge sys_clk_i) clr_i <= 1'b1;
		@(posedge sys_clk_i) clr_i <= 1'b0;
		cyc(1);
		exp = '0;
	endtask
	task automatic fire(input logic w, input logic s);
		@(posedge sys_clk_i) {dog_i, stop_i} <= {w, s};
		@(posedge sys_clk_i) {dog_i, stop_i} <= 2'b00;
		#1;
	endtask
	task automatic summarize;
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		cyc(11);
		@(posedge sys_clk_i) nrst_i <= 1'b1;
		cyc(2);
		exp = '0;
		chk(rst_n === 1'b0, "power-on low");
		chk_cause;
		settle(PH - 4, PH + 2);
		// lengths 1..5 straddle the qualifying count
		for (int l = 1; l <= 5; l++) begin
			cyc({$random(seed)} % 8);
			@(posedge sys_clk_i) {go, len} <= {1'b1, l[3:0]};
			@(posedge sys_clk_i) go <= 1'b0;
			n = 0;
			while (rst_n === 1'b1 && n < 12) begin
				n++;
				cyc(1);
			end
			chk(rst_n === (l < 3), "pin qualification");
			if (l >= 3)
				exp.pin = 1'b1;
			settle(0, 12);
			chk_cause;
			clear;
		end
		fire(1'b1, 1'b0);
		exp.watchdog_cause_flag = 1'b1;
		chk(rst_n === 1'b0 && irq === 1'b0, "watchdog reset");
		chk_cause;
		settle(SH, SH);
		clear;
		@(posedge sys_clk_i) opt_i <= 1'b0;
		fire(1'b1, 1'b0);
		chk(irq === 1'b1 && rst_n === 1'b1, "interrupt only");
		cyc(1);
		chk(irq === 1'b0 && rst_n === 1'b1, "interrupt one cycle");
		chk_cause;
		@(posedge sys_clk_i) opt_i <= 1'b1;
		// stop exit and a clear in one cycle: the set must survive
		@(posedge sys_clk_i) {stop_i, clr_i} <= 2'b11;
		@(posedge sys_clk_i) {stop_i, clr_i} <= 2'b00;
		#1;
		exp.stop_exit = 1'b1;
		chk_cause;
		settle(SH, SH);
		clear;
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk_i) {por_i, bo_i} <= {k[0], ~k[0]};
			cyc(3 + {$random(seed)} % 8);
			exp.por = k[0];
			exp.brownout = ~k[0];
			chk(rst_n === 1'b0, "level reset");
			chk_cause;
			@(posedge sys_clk_i) {por_i, bo_i} <= 2'b00;
			settle(PH, PH + 4);
			clear;
		end
		summarize;
	end

	initial begin
		#100000;
		fail("timeout");
		summarize;
	end
endmodule
